// [design/dscp_pkg.sv]
// Shared constants for the serial converter control port
package dscp_pkg;
    localparam int          FRAME_W      = 24;
    localparam int          DATA_W       = 20;
    localparam int          CODE_W       = 18;
    localparam int          RW_BIT       = 23;
    localparam int          ADDR_HI      = 22;
    localparam int          ADDR_LO      = 20;
    localparam int          CODE_HI      = 19;
    localparam int          CODE_LO      = 2;
    localparam logic [2:0]  ADDR_NOOP    = 3'h0;
    localparam logic [2:0]  ADDR_CODE    = 3'h1;
    localparam logic [2:0]  ADDR_CTRL    = 3'h2;
    localparam logic [2:0]  ADDR_CLRCODE = 3'h3;
    localparam logic [2:0]  ADDR_SWCTRL  = 3'h4;
    localparam int          SW_CLR_BIT   = 2;
    localparam int          SW_RST_BIT   = 1;
    localparam logic [19:0] CTRL_RESET   = 20'h00016;
    localparam int          SDO_DIS_BIT  = 5;
    localparam logic [19:0] CLRCODE_RST  = 20'h00000;
    localparam logic [19:0] CODE_RESET   = 20'h00000;
    // Host clock divider: half period of link clock in core cycles
    localparam int          LINK_HALF    = 4;
    // Avalon register offsets of the host
    localparam logic [3:0]  HOST_TXD     = 4'h0;
    localparam logic [3:0]  HOST_CMD     = 4'h4;
    localparam logic [3:0]  HOST_STAT    = 4'h8;
    localparam logic [3:0]  HOST_RXD     = 4'hC;
    localparam logic [31:0] BAD_ADDR_VAL = 32'hDEADBEEF;
endpackage

// [design/dscp_link_if.sv]
// Serial link between host master and converter port
`timescale 1ns/100ps
interface dscp_link_if;
    logic sclk;       // Serial clock
    logic sel_n;      // Frame select, active low
    logic sdi;        // Serial data to device
    logic serial_data_out;        // Device serial out level
    logic sdo_oe;     // Device drives serial out
    logic load_update_n;
    logic clear_n;
    logic reset_n;
    modport device (input sclk, sel_n, sdi, load_update_n, clear_n, reset_n,
                    output serial_data_out, sdo_oe);
    modport host (output sclk, sel_n, sdi, load_update_n, clear_n, reset_n,
                  input serial_data_out, sdo_oe);
endinterface

// [design/dscp_sync.sv]
// Two flop synchroniser with edge detection on the second stage
`timescale 1ns/100ps
module dscp_sync #(
    parameter logic INIT = 1'b0
) (
    input  wire logic core_clk_i,  // Core clock
    input  wire logic rst_b_i,     // Async reset, active low
    input  wire logic async_i,     // Raw pin
    output logic      level_o,     // Synchronised level
    output logic      rise_o,      // One-cycle rising pulse
    output logic      fall_o       // One-cycle falling pulse
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // Two stages then history for edges
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_q <= INIT;
            sync_q <= INIT;
            prev_q <= INIT;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_o = sync_q;
    assign rise_o  = sync_q & ~prev_q;
    assign fall_o  = ~sync_q & prev_q;
endmodule

// [design/dscp_device.sv]
// Converter serial control port, device end
`timescale 1ns/100ps
// Notes on behaviour
// - 24-bit shift register, MSB first
// - Bit 23 flag, 22..20 address, 19..0 data
// - Flag 0: addresses 1..4 are writes
// - Address 0 no-op; flag 1 reads 1..3
// - Shift only while frame select low
// - Exactly 24 edges, else frame discarded
// - Select rise commits frame to register
// - Overflow bits leave on serial out
// - Chain of N needs 24 times N clocks
// - Select high blocks further shifting
// - Chain never mixes code and other writes
// - Read data shifts out next frame
// - Host clocks readback with next frame
// - Serial out enabled after reset
// - Load-update low while shifting: immediate update
// - Load-update high: update at its fall
// - Reset pin low ignores all programming
// - Reset pin low or software reset restores defaults
// - Clear low loads clearcode, blocks updates
// - Output keeps clearcode until new load
// - Software clear bit acts as clear
// - Code from bits 19..2
// - Clearcode resets to zero
module dscp_device
    import dscp_pkg::*;
(
    input  wire logic                core_clk_i,  // Core clock
    input  wire logic                rst_b_i,     // Async reset, active low
    dscp_link_if.device              link,        // Serial link
    output logic [CODE_W-1:0]        out_code_o,  // Code applied to output
    output logic [DATA_W-1:0]        ctrl_o,      // Control register
    output logic                     frame_err_o  // Pulse: frame discarded
);
    logic              sclk_r, sclk_f, sel_lvl, sel_r, sel_f, ld_lvl, ld_f, clr_lvl;
    logic              rstp_lvl;
    logic              sdi_lvl;
    logic [FRAME_W-1:0] shift_q;
    logic [7:0]        cnt_q;
    logic              in_frame_q;
    logic              ld_low_q;
    logic [DATA_W-1:0] code_q, clrcode_q, ctrl_q;
    logic [CODE_W-1:0] out_q;
    logic              pend_q;
    logic [FRAME_W-1:0] rd_q;
    logic              sdo_q, oe_q, err_q;
    logic              sw_rst, sw_clr, clr_act, commit, valid;
    logic [2:0]        addr;
    logic              rw;

    dscp_sync #(.INIT(1'b0)) u_sclk (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .async_i(link.sclk), .level_o(), .rise_o(sclk_r), .fall_o(sclk_f));
    dscp_sync #(.INIT(1'b1)) u_sel (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .async_i(link.sel_n), .level_o(sel_lvl), .rise_o(sel_r), .fall_o(sel_f));
    dscp_sync #(.INIT(1'b1)) u_ld (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .async_i(link.load_update_n), .level_o(ld_lvl), .rise_o(), .fall_o(ld_f));
    dscp_sync #(.INIT(1'b1)) u_clr (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .async_i(link.clear_n), .level_o(clr_lvl), .rise_o(), .fall_o());
    dscp_sync #(.INIT(1'b0)) u_rst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .async_i(link.reset_n), .level_o(rstp_lvl), .rise_o(), .fall_o());
    dscp_sync #(.INIT(1'b0)) u_sdi (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .async_i(link.sdi), .level_o(sdi_lvl), .rise_o(), .fall_o());

    // Frame fields
    assign rw     = shift_q[RW_BIT];
    assign addr   = shift_q[ADDR_HI:ADDR_LO];
    assign valid  = (cnt_q == 8'(FRAME_W));
    assign commit = sel_r && in_frame_q && valid && rstp_lvl;
    assign sw_rst = commit && !rw && addr == ADDR_SWCTRL && shift_q[SW_RST_BIT];
    assign sw_clr = commit && !rw && addr == ADDR_SWCTRL && shift_q[SW_CLR_BIT];
    assign clr_act = !clr_lvl || sw_clr;

    // Shift in on falling serial clock inside frame
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shift_q    <= '0;
            cnt_q      <= '0;
            in_frame_q <= 1'b0;
            ld_low_q   <= 1'b0;
        end else if (!rstp_lvl) begin
            in_frame_q <= 1'b0;
            cnt_q      <= '0;
        end else if (sel_f) begin
            in_frame_q <= 1'b1;
            cnt_q      <= '0;
            ld_low_q   <= !ld_lvl;
        end else if (sel_r) begin
            in_frame_q <= 1'b0;
        end else if (in_frame_q && !sel_lvl && sclk_f) begin
            shift_q  <= {shift_q[FRAME_W-2:0], sdi_lvl};
            if (cnt_q != 8'hFF) cnt_q <= cnt_q + 8'h01;
            if (ld_lvl) ld_low_q <= 1'b0;
        end
    end

    // Registers written by committed frames
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            code_q    <= CODE_RESET;
            clrcode_q <= CLRCODE_RST;
            ctrl_q    <= CTRL_RESET;
            pend_q    <= 1'b0;
            out_q     <= '0;
        end else if (!rstp_lvl || sw_rst) begin
            code_q    <= CODE_RESET;
            clrcode_q <= CLRCODE_RST;
            ctrl_q    <= CTRL_RESET;
            pend_q    <= 1'b0;
            out_q     <= '0;
        end else if (clr_act) begin
            code_q <= clrcode_q;
            out_q  <= clrcode_q[CODE_HI:CODE_LO];
            pend_q <= 1'b0;
        end else begin
            if (commit && !rw) begin
                case (addr)
                    ADDR_CODE: begin
                        code_q <= shift_q[DATA_W-1:0];
                        if (ld_low_q) out_q <= shift_q[CODE_HI:CODE_LO];
                        pend_q <= !ld_low_q;
                    end
                    ADDR_CTRL:    ctrl_q    <= shift_q[DATA_W-1:0];
                    ADDR_CLRCODE: clrcode_q <= shift_q[DATA_W-1:0];
                    default: ;
                endcase
            end else if (pend_q && ld_f && sel_lvl) begin
                out_q  <= code_q[CODE_HI:CODE_LO];
                pend_q <= 1'b0;
            end
        end
    end

    // Serial out: overflow bits or pending readback
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_q  <= '0;
            sdo_q <= 1'b0;
            oe_q  <= 1'b0;
            err_q <= 1'b0;
        end else begin
            err_q <= sel_r && in_frame_q && !valid;
            if (commit && rw && addr != ADDR_NOOP) begin
                case (addr)
                    ADDR_CODE:    rd_q <= {shift_q[FRAME_W-1:DATA_W], code_q};
                    ADDR_CTRL:    rd_q <= {shift_q[FRAME_W-1:DATA_W], ctrl_q};
                    ADDR_CLRCODE: rd_q <= {shift_q[FRAME_W-1:DATA_W], clrcode_q};
                    default:      rd_q <= '0;
                endcase
            end else if (commit) begin
                rd_q <= shift_q;
            end
            if (sel_r || !rstp_lvl) begin
                oe_q <= 1'b0;
            end else if (in_frame_q && !sel_lvl && !ctrl_q[SDO_DIS_BIT]) begin
                oe_q <= 1'b1;
            end
            if (sel_f) begin
                sdo_q <= rd_q[FRAME_W-1];
            end else if (in_frame_q && sclk_r) begin
                sdo_q <= (cnt_q >= 8'(FRAME_W)) ? shift_q[FRAME_W-1]
                                                : rd_q[FRAME_W-1-cnt_q[4:0]];
            end
        end
    end

    assign link.serial_data_out    = sdo_q;
    assign link.sdo_oe = oe_q;
    assign out_code_o  = out_q;
    assign ctrl_o      = ctrl_q;
    assign frame_err_o = err_q;
endmodule

// [design/dscp_host.sv]
// Host serial master with Avalon-MM command registers
`timescale 1ns/100ps
module dscp_host
    import dscp_pkg::*;
(
    input  wire logic        core_clk_i,       // Core clock
    input  wire logic        rst_b_i,          // Async reset, active low
    input  wire logic [3:0]  avs_address,      // Byte address
    input  wire logic        avs_read,         // Read strobe
    input  wire logic        avs_write,        // Write strobe
    input  wire logic [31:0] avs_writedata,    // Write data
    output logic [31:0]      avs_readdata,     // Read data
    output logic             avs_waitrequest,  // Stall
    input  wire logic        ld_n_i,           // Load-update pin level
    input  wire logic        clr_n_i,          // Clear pin level
    input  wire logic        dev_rst_n_i,      // Device reset pin level
    dscp_link_if.host        link              // Serial link
);
    typedef enum logic [1:0] {DSCP_IDLE = 2'b00, DSCP_LOW = 2'b01,
                              DSCP_HIGH = 2'b11, DSCP_END = 2'b10} dscp_st_t;
    dscp_st_t          st_q;
    logic [FRAME_W-1:0] tx_q, rx_q;
    logic [7:0]        frames_q, left_q;
    logic [7:0]        div_q;
    logic [4:0]        bit_q;
    logic              sclk_q, sel_q, busy_q;
    logic              sdo_lvl;
    logic [31:0]       rdata_q;
    logic              ack_q;
    logic              go;

    dscp_sync #(.INIT(1'b0)) u_sdo (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .async_i(link.serial_data_out), .level_o(sdo_lvl), .rise_o(), .fall_o());

    // Writes land at the edge where waitrequest is low
    assign go = avs_write && ack_q && avs_address == HOST_CMD && !busy_q;

    // Avalon slave: one wait cycle per access
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_q   <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= (avs_read || avs_write) && !ack_q;
            case (avs_address)
                HOST_TXD:  rdata_q <= {8'h00, tx_q};
                HOST_CMD:  rdata_q <= {24'h000000, frames_q};
                HOST_STAT: rdata_q <= {31'h00000000, busy_q};
                HOST_RXD:  rdata_q <= {8'h00, rx_q};
                default:   rdata_q <= BAD_ADDR_VAL;
            endcase
        end
    end
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign avs_readdata    = rdata_q;

    // Frame engine: 24 times N clocks per frame select
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q     <= DSCP_IDLE;
            tx_q     <= '0;
            rx_q     <= '0;
            frames_q <= 8'h01;
            left_q   <= '0;
            div_q    <= '0;
            bit_q    <= '0;
            sclk_q   <= 1'b0;
            sel_q    <= 1'b1;
            busy_q   <= 1'b0;
        end else begin
            if (avs_write && ack_q && avs_address == HOST_TXD && !busy_q)
                tx_q <= avs_writedata[FRAME_W-1:0];
            if (go) begin
                frames_q <= (avs_writedata[7:0] == 8'h00) ? 8'h01 : avs_writedata[7:0];
                left_q   <= (avs_writedata[7:0] == 8'h00) ? 8'h01 : avs_writedata[7:0];
                busy_q   <= 1'b1;
                sel_q    <= 1'b0;
                sclk_q   <= 1'b1;                               // Idle rise, first fall takes bit 23
                bit_q    <= 5'(FRAME_W - 1);
                div_q    <= '0;
                st_q     <= DSCP_HIGH;
            end else begin
                case (st_q)
                    DSCP_IDLE: ;
                    DSCP_HIGH: begin
                        div_q <= div_q + 8'h01;
                        if (div_q == 8'(LINK_HALF - 1)) begin
                            div_q  <= '0;
                            sclk_q <= 1'b0;
                            st_q   <= DSCP_LOW;
                        end
                    end
                    DSCP_LOW: begin
                        div_q <= div_q + 8'h01;
                        if (div_q == 8'(LINK_HALF - 1)) begin
                            div_q  <= '0;
                            sclk_q <= 1'b1;
                            // Serial out settles late, so sample just before the rise
                            rx_q   <= {rx_q[FRAME_W-2:0], sdo_lvl};
                            tx_q   <= {tx_q[FRAME_W-2:0], tx_q[FRAME_W-1]};
                            if (bit_q == 5'h00) begin
                                bit_q <= 5'(FRAME_W - 1);
                                left_q <= left_q - 8'h01;
                                st_q <= (left_q == 8'h01) ? DSCP_END : DSCP_HIGH;
                            end else begin
                                bit_q <= bit_q - 5'h01;
                                st_q  <= DSCP_HIGH;
                            end
                        end
                    end
                    DSCP_END: begin
                        div_q <= div_q + 8'h01;
                        if (div_q == 8'(LINK_HALF - 1)) begin
                            sel_q  <= 1'b1;
                            busy_q <= 1'b0;
                            div_q  <= '0;
                            st_q   <= DSCP_IDLE;
                        end
                    end
                    default: st_q <= DSCP_IDLE;
                endcase
            end
        end
    end

    assign link.sclk          = sclk_q;
    assign link.sel_n         = sel_q;
    assign link.sdi           = tx_q[FRAME_W-1];
    assign link.load_update_n = ld_n_i;
    assign link.clear_n       = clr_n_i;
    assign link.reset_n       = dev_rst_n_i;
endmodule

// [bench/dscp_link_asserts.sv]
// Concurrent checks on the serial link between host and converter port
`timescale 1ns/100ps
module dscp_link_asserts
    import dscp_pkg::*;
(
    input wire logic              core_clk_i,    // Core clock
    input wire logic              rst_b_i,       // Async reset, active low
    input wire logic              sclk,          // Serial clock
    input wire logic              sel_n,         // Frame select, active low
    input wire logic              serial_data_out,           // Device serial out
    input wire logic              sdo_oe,        // Device drives serial out
    input wire logic              load_update_n, // Load-update pin
    input wire logic              clear_n,       // Clear pin
    input wire logic              reset_n,       // Device reset pin
    input wire logic [CODE_W-1:0] out_code_o,    // Applied code
    input wire logic [DATA_W-1:0] ctrl_o,        // Control register
    input wire logic              frame_err_o    // Discard pulse
);
    logic       sclk_q;
    logic       sel_q;
    logic       ld_q;
    logic [5:0] fall_cnt_q;
    logic [3:0] since_q;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    // Pin history, falls per frame, cycles since last update cause
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sclk_q     <= 1'b0;
            sel_q      <= 1'b1;
            ld_q       <= 1'b1;
            fall_cnt_q <= 6'h00;
            since_q    <= 4'h0;
        end else begin
            sclk_q <= sclk;
            sel_q  <= sel_n;
            ld_q   <= load_update_n;
            if (sel_q && !sel_n) fall_cnt_q <= 6'h00;
            else if (!sel_n && sclk_q && !sclk && fall_cnt_q != 6'h3F)
                fall_cnt_q <= fall_cnt_q + 6'h01;
            if ((ld_q && !load_update_n) || (!sel_q && sel_n) || !clear_n || !reset_n)
                since_q <= 4'h0;
            else if (since_q != 4'hF)
                since_q <= since_q + 4'h1;
        end
    end

    sequence seq_shift_edge;
        $fell(sclk) && sdo_oe;
    endsequence
    sequence seq_frame_end;
        $rose(sel_n) && reset_n;
    endsequence

    a_rise_in_frame: assert property ($rose(sclk) |-> !sel_n)
        else $error("serial clock rose outside a frame");
    a_count_whole: assert property ($rose(sel_n) |->
        fall_cnt_q % 24 == 0 && fall_cnt_q != 0)
        else $error("frame length not a whole number of words");
    a_err_cause: assert property (frame_err_o |-> fall_cnt_q != 6'd24)
        else $error("discard flagged on a full frame");
    a_err_flag: assert property (seq_frame_end ##0 fall_cnt_q != 6'd24 |->
        ##[1:6] frame_err_o)
        else $error("bad frame length not flagged");
    a_sdo_release: assert property ($rose(sel_n) |-> ##[0:5] !sdo_oe)
        else $error("serial out still driven after frame end");
    a_sdo_steady: assert property (seq_shift_edge |-> $stable(serial_data_out) [*3])
        else $error("serial out moved near a falling clock");
    a_rst_defaults: assert property (!reset_n [*4] |->
        out_code_o == '0 && ctrl_o == CTRL_RESET)
        else $error("registers not at defaults while reset pin low");
    a_clear_holds: assert property (!clear_n [*4] ##1 !clear_n |-> $stable(out_code_o))
        else $error("output code moved while clear held");
    a_update_cause: assert property ($changed(out_code_o) |-> since_q < 4'h8)
        else $error("output code changed without a cause");
endmodule

// [bench/tb.sv]
// Self-checking bench: host and converter port joined on one link
`timescale 1ns/100ps
module tb;
    import dscp_pkg::*;
    logic                core_clk_i = 1'b0;
    logic                rst_b_i = 1'b0;
    logic [3:0]          avs_address = 4'h0;
    logic                avs_read = 1'b0;
    logic                avs_write = 1'b0;
    logic [31:0]         avs_writedata = 32'h0;
    logic [31:0]         avs_readdata;
    logic                avs_waitrequest;
    logic                ld_n = 1'b0;
    logic                clr_n = 1'b1;
    logic                dev_rst_n = 1'b1;
    logic                rd_noted = 1'b0;
    logic [CODE_W-1:0]   out_code;
    logic [DATA_W-1:0]   ctrl;
    logic                ferr;
    logic [63:0]         exp_q[$];
    logic [31:0]         seed = 32'h000050F3;
    logic [31:0]         d;
    logic [31:0]         c;
    logic [31:0]         q;
    int                  fail_count = 0;
    int                  n_checks = 0;
    int                  n_err = 0;
    int                  e0;
    dscp_link_if lnk();
    dscp_host i_dscp_host(.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ld_n_i(ld_n),
        .clr_n_i(clr_n), .dev_rst_n_i(dev_rst_n), .link(lnk.host));
    dscp_device i_dscp_device(.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .link(lnk.device),
        .out_code_o(out_code), .ctrl_o(ctrl), .frame_err_o(ferr));
    dscp_link_asserts i_dscp_link_asserts(.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .sclk(lnk.sclk), .sel_n(lnk.sel_n), .serial_data_out(lnk.serial_data_out), .sdo_oe(lnk.sdo_oe),
        .load_update_n(lnk.load_update_n), .clear_n(lnk.clear_n), .reset_n(lnk.reset_n),
        .out_code_o(out_code), .ctrl_o(ctrl), .frame_err_o(ferr));

    // 10 MHz core clock
    always #50 core_clk_i = ~core_clk_i;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // One Avalon transfer; request held until waitrequest seen low
    task automatic av(input logic [3:0] a, input logic wr, input logic [31:0] wd,
                      input logic nt, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge core_clk_i);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        rd_noted <= nt;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        rd = avs_readdata;
        if (n >= 100) begin
            fail_count++;
            tally_and_finish();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic rd_exp(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        exp_q.push_back({m, e});
        av(a, 1'b0, 32'h0, 1'b1, q);
    endtask

    // Send one frame of nf copies of one word and wait for the host to go idle
    // One word per chain, so code and other writes never mix
    task automatic send(input logic [23:0] w, input logic [31:0] nf);
        int n;
        n = 0;
        av(HOST_TXD, 1'b1, {8'h00, w}, 1'b0, q);
        av(HOST_CMD, 1'b1, nf, 1'b0, q);
        do begin
            av(HOST_STAT, 1'b0, 32'h0, 1'b0, q);
            n++;
        end while (q[0] !== 1'b0 && n < 400);
        if (n >= 400) begin
            fail_count++;
            tally_and_finish();
        end
        repeat (6) @(posedge core_clk_i);
    endtask

    // Read data compared against the oldest noted expectation
    always @(posedge core_clk_i) begin
        if (avs_read && avs_waitrequest === 1'b0 && rd_noted && exp_q.size() > 0) begin
            check("readdata", avs_readdata & exp_q[0][63:32], exp_q[0][31:0]);
            void'(exp_q.pop_front());
        end
    end

    // Count discard pulses
    always @(posedge core_clk_i) begin
        if (ferr === 1'b1) n_err++;
    end

    initial begin
        repeat (10) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        check("ctrl", 32'(ctrl), 32'(CTRL_RESET));
        check("code", 32'(out_code), 32'h0);
        rd_exp(4'h2, 32'hFFFFFFFF, BAD_ADDR_VAL);
        $display("test reset done");
        d = rnd();
        send({1'b0, ADDR_CODE, d[19:0]}, 1);
        check("code", 32'(out_code), 32'(d[19:2]));
        send({1'b0, ADDR_CTRL, 20'h00012}, 1);
        check("ctrl", 32'(ctrl), 32'h00012);
        send({1'b1, ADDR_CTRL, 20'h00000}, 1);
        send({1'b1, ADDR_CODE, 20'h00000}, 1);
        rd_exp(HOST_RXD, 32'h000FFFFF, 32'h00012);
        send({1'b0, ADDR_NOOP, 20'h00000}, 1);
        rd_exp(HOST_RXD, 32'h000FFFFC, {12'h000, d[19:2], 2'b00});
        $display("test sync write and readback done");
        ld_n <= 1'b1;
        c = rnd();
        send({1'b0, ADDR_CODE, c[19:0]}, 1);
        check("code", 32'(out_code), 32'(d[19:2]));
        ld_n <= 1'b0;
        repeat (6) @(posedge core_clk_i);
        check("code", 32'(out_code), 32'(c[19:2]));
        $display("test deferred update done");
        c = rnd();
        send({1'b0, ADDR_CLRCODE, c[19:0]}, 1);
        send({1'b1, ADDR_CLRCODE, 20'h00000}, 1);
        send({1'b0, ADDR_NOOP, 20'h00000}, 1);
        rd_exp(HOST_RXD, 32'h000FFFFC, {12'h000, c[19:2], 2'b00});
        clr_n <= 1'b0;
        repeat (6) @(posedge core_clk_i);
        check("code", 32'(out_code), 32'(c[19:2]));
        d = rnd();
        send({1'b0, ADDR_CODE, d[19:0]}, 1);
        check("code", 32'(out_code), 32'(c[19:2]));
        ld_n <= 1'b1;
        clr_n <= 1'b1;
        repeat (6) @(posedge core_clk_i);
        check("code", 32'(out_code), 32'(c[19:2]));
        ld_n <= 1'b0;
        send({1'b0, ADDR_CODE, d[19:0]}, 1);
        check("code", 32'(out_code), 32'(d[19:2]));
        send({1'b0, ADDR_SWCTRL, 20'h00004}, 1);
        check("code", 32'(out_code), 32'(c[19:2]));
        $display("test clear done");
        send({1'b0, ADDR_SWCTRL, 20'h00002}, 1);
        check("ctrl", 32'(ctrl), 32'(CTRL_RESET));
        check("code", 32'(out_code), 32'h0);
        e0 = n_err;
        d = rnd();
        send({1'b0, ADDR_CODE, d[19:0]}, 2);
        check("discards", 32'(n_err - e0), 32'h1);
        check("code", 32'(out_code), 32'h0);
        rd_exp(HOST_RXD, 32'h00FFFFFF, {8'h00, 1'b0, ADDR_CODE, d[19:0]});
        $display("test overlong frame done");
        send({1'b0, ADDR_CTRL, 20'h00012}, 1);
        dev_rst_n <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        send({1'b0, ADDR_CTRL, 20'h00008}, 1);
        check("ctrl", 32'(ctrl), 32'(CTRL_RESET));
        dev_rst_n <= 1'b1;
        repeat (6) @(posedge core_clk_i);
        check("ctrl", 32'(ctrl), 32'(CTRL_RESET));
        $display("test reset pin done");
        tally_and_finish();
    end
endmodule
